/* bfs_top.sv */
// Fault supervision and light-load mode control for a synchronous buck.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module bfs_top
  import bfs_pkg::*;
#(
  parameter int DSCH_HOLD = bfs_pkg::DSCH_HOLD_CYC,
  parameter int CUR_WIDTH = bfs_pkg::CUR_W
) (
  // Clock and reset.
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // Host and supply pins, all asynchronous.
  input  wire logic                  enable_in,
  input  wire logic                  bias_ok_in,
  input  wire logic                  input_ok_in,
  input  wire logic                  over_temp_in,
  // Window comparators against internal and external reference.
  input  wire logic                  ext_ref_in_use,
  input  wire logic                  uv_cmp_int,
  input  wire logic                  uv_cmp_ext,
  input  wire logic                  ov_cmp_int,
  input  wire logic                  ov_cmp_ext,
  input  wire logic                  oob_cmp,
  input  wire logic                  fb_below_100mv,
  // Analog loop and soft-start status.
  input  wire logic                  softstart_done_in,
  input  wire logic                  pwm_request_in,
  input  wire logic                  on_time_done_in,
  input  wire logic [CUR_WIDTH-1:0]  ls_current_ma,
  input  wire logic [15:0]           limit_set_resistance,
  // Mode strap and its calibration window.
  input  wire logic [2:0]            mode_strap_in,
  input  wire logic                  cal_window_in,
  // Register port.
  input  wire logic [bfs_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic [31:0]                reg_rdata,
  // Gate drive and housekeeping outputs.
  output logic                       hs_drive,
  output logic                       ls_drive,
  output logic                       discharge_on,
  output logic                       regulator_on,
  output logic                       softstart_reset,
  output logic                       skip_mode,
  output logic                       light_load,
  output logic [1:0]                 freq_sel,
  // Open-drain power-good pin.
  output logic                       power_ok_out,
  output logic                       power_ok_oe
);
  import bfs_pkg::*;

  // ==========================================================================
  // Parameter checks
  // ==========================================================================
  generate
    if (CUR_WIDTH < 13 || CUR_WIDTH > 16)
    begin : g_cur_chk
      $error("bfs_top: CUR_WIDTH must lie between 13 and 16");
    end
    if (DSCH_HOLD < 1 || DSCH_HOLD >= 65536)
    begin : g_hold_chk
      $error("bfs_top: DSCH_HOLD must fit the delay timer");
    end
  endgenerate

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  localparam int NSYNC = 14 + CUR_WIDTH + 3;

  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;

  assign async_in = {enable_in, bias_ok_in, input_ok_in, over_temp_in,
                     ext_ref_in_use, uv_cmp_int, uv_cmp_ext, ov_cmp_int,
                     ov_cmp_ext, oob_cmp, fb_below_100mv, softstart_done_in,
                     pwm_request_in, on_time_done_in, ls_current_ma,
                     mode_strap_in};

  // Every pin in async_in passes two flops; only the second stage feeds logic.
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge clock)
      begin
        if (!rst_n)
        begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end
        else
        begin
          sync_a[gi] <= async_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  logic                        en_s;
  logic                        bias_s;
  logic                        vin_s;
  logic                        hot_s;
  logic                        ext_s;
  logic                        uvi_s;
  logic                        uve_s;
  logic                        ovi_s;
  logic                        ove_s;
  logic                        oob_s;
  logic                        fb_low_s;
  logic                        ss_done_s;
  logic                        pwm_s;
  logic                        ton_done_s;
  logic signed [CUR_WIDTH-1:0] cur_s;
  logic [2:0]                  strap_s;

  assign {en_s, bias_s, vin_s, hot_s, ext_s, uvi_s, uve_s, ovi_s, ove_s,
          oob_s, fb_low_s, ss_done_s, pwm_s, ton_done_s, cur_s,
          strap_s} = sync_b;

  // ==========================================================================
  // Comparator selection and current limits
  // ==========================================================================
  logic        uv_s;
  logic        ov_s;
  logic [31:0] cur_pos;
  logic [31:0] cur_x_r;
  logic        limit_set_input_clamped;
  logic        valley_over;
  logic        neg_limit;
  logic        zero_cross;

  // The window follows whichever reference is steering the loop.
  assign uv_s = ext_s ? uve_s : uvi_s;
  assign ov_s = ext_s ? ove_s : ovi_s;

  // Compare I*R against 30000 instead of dividing; no divider needed.
  assign cur_pos      = cur_s[CUR_WIDTH-1] ? 32'h0000_0000
                        : 32'(unsigned'(cur_s));
  assign cur_x_r      = 32'(cur_pos * 32'(limit_set_resistance));
  assign limit_set_input_clamped = limit_set_resistance < LIMIT_SET_INPUT_MIN_OHM;
  assign valley_over  = limit_set_input_clamped ? (cur_pos > 32'(CLAMP_MA))
                        : (cur_x_r > VALLEY_NUM);
  assign neg_limit    = cur_s <= CUR_WIDTH'(NEG_LIMIT_MA);
  assign zero_cross   = cur_s[CUR_WIDTH-1] || (cur_s == '0);

  // ==========================================================================
  // Supply conditions
  // ==========================================================================
  logic dsch_req;
  logic restart_evt;

  // Any of these stops switching and restarts soft start later.
  assign dsch_req    = !en_s || hot_s || !bias_s || !vin_s;
  // Only enable low or bias loss may clear latched faults.
  assign restart_evt = !en_s || !bias_s;

  // ==========================================================================
  // Mode strap capture
  // ==========================================================================
  logic [1:0] next_freq;

  assign next_freq = (strap_s == MODE_TIED_BIAS || strap_s == MODE_TIED_GND)
                     ? FREQ_1100K
                     : ((strap_s == MODE_R243K || strap_s == MODE_R30K1)
                        ? FREQ_2200K : FREQ_600K);

  // The strap is only believed inside the calibration window.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      skip_mode <= 1'b0;
      freq_sel  <= FREQ_600K;
    end
    else if (cal_window_in)
    begin
      skip_mode <= (strap_s <= MODE_R121K);
      freq_sel  <= next_freq;
    end
  end

  // ==========================================================================
  // Register port
  // ==========================================================================
  logic       skip_en;
  logic       sel_ctrl;
  logic       sel_status;
  logic       sel_light;
  logic [4:0] zc_count;
  logic [31:0] next_rdata;
  bfs_state_t state;
  bfs_phase_t phase;
  logic       fault;
  logic       pg_lost;
  logic       pg_good;
  logic       ocl_in_ss;

  assign sel_ctrl   = reg_addr == REG_CTRL;
  assign sel_status = reg_addr == REG_STATUS;
  assign sel_light  = reg_addr == REG_LIGHT;
  assign next_rdata = !reg_read ? 32'h0000_0000
    : sel_ctrl   ? {31'h0000_0000, skip_en}
    : sel_status ? {20'h0_0000, state, ov_s, oob_s, ocl_in_ss, pg_lost,
                    skip_mode, fault, pg_good, discharge_on}
    : sel_light  ? {22'h00_0000, phase, light_load, 1'b0, zc_count}
    : 32'h0000_0000;

  // Software may veto skip operation; unmapped reads return zero.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      skip_en   <= CTRL_SKIP_RST;
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      if (reg_write && sel_ctrl)
        skip_en <= reg_wdata[CTRL_SKIP_EN];
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // Supervisor state machine
  // ==========================================================================
  bfs_state_t next_state;
  logic       uv_run;
  logic       uv_expired;
  logic       pg_run;
  logic       pg_expired;

  // Undervoltage counts only once soft start is over.
  assign uv_run = (state == ST_RUN) && (uv_s || ocl_in_ss);

  bfs_delay #(.WIDTH(TIMER_W)) u_uv_delay (
    .clock   (clock),
    .rst_n   (rst_n),
    .run     (uv_run),
    .limit   (TIMER_W'(UV_DELAY_CYC)),
    .expired (uv_expired),
    .count   ()
  );

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_OFF:
        if (!dsch_req)
          next_state = ST_SS;
      ST_SS:
        if (dsch_req)
          next_state = ST_OFF;
        else if (ss_done_s)
          next_state = ST_RUN;
      ST_RUN:
        if (dsch_req)
          next_state = ST_OFF;
        else if (uv_expired)
          next_state = ST_LATCH;
      ST_LATCH:
        if (restart_evt)
          next_state = ST_OFF;
      default:
        next_state = ST_OFF;
    endcase
  end

  // The fault flag is loaded from next_state, so it records a latch-off in step with state.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state     <= ST_OFF;
      fault     <= 1'b0;
      ocl_in_ss <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      fault     <= (next_state == ST_LATCH);
      if (state == ST_OFF)
        ocl_in_ss <= 1'b0;
      else if (state == ST_SS && valley_over)
        ocl_in_ss <= 1'b1;
    end
  end

  // ==========================================================================
  // Power-good window and latch
  // ==========================================================================
  assign pg_run = (state == ST_RUN) && pg_good && (uv_s || ov_s);

  bfs_delay #(.WIDTH(TIMER_W)) u_pg_delay (
    .clock   (clock),
    .rst_n   (rst_n),
    .run     (pg_run),
    .limit   (TIMER_W'(PG_DELAY_CYC)),
    .expired (pg_expired),
    .count   ()
  );

  // Power-good stays high through a short excursion, then latches low.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pg_lost      <= 1'b0;
      pg_good      <= 1'b0;
      power_ok_oe  <= 1'b1;
      power_ok_out <= 1'b0;
    end
    else
    begin
      if (pg_expired)
        pg_lost <= 1'b1;
      else if (restart_evt)
        pg_lost <= 1'b0;
      if (pg_expired || state != ST_RUN || pg_lost)
        pg_good <= 1'b0;
      else if (!uv_s && !ov_s)
        pg_good <= 1'b1;
      power_ok_oe  <= !pg_good;
      power_ok_out <= 1'b0;
    end
  end

  // ==========================================================================
  // Discharge and regulator control
  // ==========================================================================
  logic hold_active;
  logic hold_expired;
  logic fb_done;
  logic next_dsch;

  bfs_delay #(.WIDTH(TIMER_W)) u_dsch_hold (
    .clock   (clock),
    .rst_n   (rst_n),
    .run     (hold_active && !dsch_req),
    .limit   (TIMER_W'(DSCH_HOLD)),
    .expired (hold_expired),
    .count   ()
  );

  assign next_dsch = (dsch_req && !fb_done)
                     || (hold_active && !dsch_req && !hold_expired);

  // A discharge that reached 100 mV stays off until the request clears.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      fb_done         <= 1'b0;
      hold_active     <= 1'b0;
      discharge_on    <= 1'b0;
      regulator_on    <= 1'b0;
      softstart_reset <= 1'b1;
    end
    else
    begin
      if (!dsch_req)
        fb_done <= 1'b0;
      else if (fb_low_s)
        fb_done <= 1'b1;
      if (dsch_req)
        hold_active <= 1'b1;
      else if (hold_expired)
        hold_active <= 1'b0;
      discharge_on    <= next_dsch;
      regulator_on    <= !(dsch_req && fb_done) && bias_s;
      softstart_reset <= (next_state == ST_OFF);
    end
  end

  // ==========================================================================
  // Switching phase machine
  // ==========================================================================
  bfs_phase_t next_phase;
  logic       switching;
  logic       skip_active;
  logic       zc_cut;

  assign switching   = (state == ST_SS || state == ST_RUN) && !dsch_req;
  // The early overvoltage guard overrides skip, forcing continuous mode.
  assign skip_active = skip_mode && skip_en && !oob_s;
  assign zc_cut      = (phase == PH_LS) && skip_active && zero_cross
                       && !ov_s && !neg_limit;

  always_comb
  begin
    next_phase = phase;
    unique case (phase)
      PH_IDLE:
        if (ov_s || oob_s)
          next_phase = PH_LS;
        else if (pwm_s)
          next_phase = PH_HS;
      PH_HS:
        // Pulse width comes from the loop's own on-time in every mode.
        if (ton_done_s)
          next_phase = PH_LS;
      PH_LS:
        if (neg_limit && (ov_s || oob_s || !skip_active))
          next_phase = PH_HS;
        else if (zc_cut)
          next_phase = PH_IDLE;
        else if (pwm_s && !valley_over && !ov_s)
          next_phase = PH_HS;
      default:
        next_phase = PH_IDLE;
    endcase
    if (!switching)
      next_phase = PH_IDLE;
  end

  // Count consecutive zero-cross cuts; a full cycle without one resets it.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      phase      <= PH_IDLE;
      zc_count   <= 5'h00;
      light_load <= 1'b0;
      hs_drive   <= 1'b0;
      ls_drive   <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      if (!switching || !skip_active)
        zc_count <= 5'h00;
      else if (zc_cut && zc_count < ZC_W'(ZC_COUNT_MAX))
        zc_count <= zc_count + 5'h01;
      else if (phase == PH_LS && next_phase == PH_HS)
        zc_count <= 5'h00;
      light_load <= skip_active && switching
                    && zc_count >= ZC_W'(ZC_COUNT_MAX);
      hs_drive   <= next_phase == PH_HS;
      ls_drive   <= next_phase == PH_LS;
    end
  end

endmodule

/* bfs_pkg.sv */
// Shared constants for the buck fault supervisor.
package bfs_pkg;

  // ==========================================================================
  // Clock and time base
  // ==========================================================================
  localparam int CLK_PERIOD_NS   = 20;
  localparam int UV_DELAY_NS     = 64000;
  localparam int PG_DELAY_NS     = 5000;
  localparam int DSCH_HOLD_NS    = 128000;
  // Least times round up to whole cycles.
  localparam int UV_DELAY_CYC    = (UV_DELAY_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int PG_DELAY_CYC    = (PG_DELAY_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int DSCH_HOLD_CYC   = (DSCH_HOLD_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int TIMER_W         = 16;

  // ==========================================================================
  // Current limits (milliamperes and ohms)
  // ==========================================================================
  localparam int          CUR_W          = 16;
  localparam logic [31:0] VALLEY_NUM     = 32'h01C9_C380; // 30000 A*ohm in mA.
  localparam logic [15:0] LIMIT_SET_INPUT_MIN_OHM   = 16'h0E9C;      // 3740 ohm.
  localparam logic [15:0] CLAMP_MA       = 16'h1F40;      // Internal clamp.
  localparam logic signed [15:0] NEG_LIMIT_MA = -16'sd3500;
  localparam int          ZC_COUNT_MAX   = 16;
  localparam int          ZC_W           = 5;

  // ==========================================================================
  // Mode strap codes, ordered from tied-to-bias down to tied-to-ground
  // ==========================================================================
  localparam logic [2:0] MODE_TIED_BIAS = 3'h0;
  localparam logic [2:0] MODE_R243K     = 3'h1;
  localparam logic [2:0] MODE_R121K     = 3'h2;
  localparam logic [2:0] MODE_R60K4     = 3'h3;
  localparam logic [2:0] MODE_R30K1     = 3'h4;
  localparam logic [2:0] MODE_TIED_GND  = 3'h5;
  localparam logic [1:0] FREQ_600K      = 2'h0;
  localparam logic [1:0] FREQ_1100K     = 2'h1;
  localparam logic [1:0] FREQ_2200K     = 2'h2;

  // ==========================================================================
  // Register map (byte addresses) and fields
  // ==========================================================================
  localparam int         ADDR_W         = 8;
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_STATUS     = 8'h04;
  localparam logic [7:0] REG_LIGHT      = 8'h08;
  localparam int         CTRL_SKIP_EN   = 0;
  localparam logic       CTRL_SKIP_RST  = 1'b1;

  // ==========================================================================
  // State machines
  // ==========================================================================
  typedef enum logic [3:0] {
    ST_OFF   = 4'b0001,
    ST_SS    = 4'b0010,
    ST_RUN   = 4'b0100,
    ST_LATCH = 4'b1000
  } bfs_state_t;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_HS   = 3'b010,
    PH_LS   = 3'b100
  } bfs_phase_t;

endpackage

/* bfs_delay.sv */
// Run-while-high delay counter with a registered expiry flag.
`timescale 1ns/1ns
module bfs_delay #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Control.
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] limit,
  // Result.
  output logic                  expired,
  output logic [WIDTH-1:0]      count
);

  generate
    if (WIDTH < 2)
    begin : g_chk
      $error("bfs_delay: WIDTH must be at least 2");
    end
  endgenerate

  logic             hit;
  logic [WIDTH-1:0] next_count;

  // Dropping run clears the count, so each new episode starts from zero.
  assign hit        = run && (count >= limit - WIDTH'(1));
  assign next_count = !run ? '0 : (hit ? count : count + WIDTH'(1));

  // Expiry is a level that holds while run stays high.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      count   <= '0;
      expired <= 1'b0;
    end
    else
    begin
      count   <= next_count;
      expired <= hit;
    end
  end

endmodule

/* bfs_top_chk.sv */
// Port-level assertions for the buck fault supervisor.
`timescale 1ns/1ns
module bfs_chk
  import bfs_pkg::*;
#(
  parameter int DSCH_HOLD = 20
) (
  // Clock and reset.
  input wire logic        clock,
  input wire logic        rst_n,
  // Inputs watched.
  input wire logic        enable_in,
  input wire logic        bias_ok_in,
  input wire logic        input_ok_in,
  input wire logic        over_temp_in,
  input wire logic        ext_ref_in_use,
  input wire logic        uv_cmp_int,
  input wire logic        softstart_done_in,
  input wire logic        cal_window_in,
  input wire logic        reg_read,
  // Outputs watched.
  input wire logic [31:0] reg_rdata,
  input wire logic        hs_drive,
  input wire logic        ls_drive,
  input wire logic        discharge_on,
  input wire logic        skip_mode,
  input wire logic        light_load,
  input wire logic        power_ok_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Held undervoltage while running; the margin covers input lag.
  logic [12:0] uv_run;
  wire uv_hold = uv_cmp_int && !ext_ref_in_use && enable_in && bias_ok_in
    && input_ok_in && !over_temp_in && softstart_done_in;
  always_ff @(posedge clock)
    if (!rst_n || !uv_hold)
      uv_run <= 13'h0000;
    else if (uv_run != 13'h1FFF)
      uv_run <= uv_run + 13'h0001;
  a_drives_apart: assert property (!(hs_drive && ls_drive))
    else $error("Both gate drives on.");
  a_dsch_drives_off: assert property
    ($rose(discharge_on) |=> !hs_drive && !ls_drive)
    else $error("Drive on after discharge entry.");
  a_dsch_hold_on: assert property
    ($rose(enable_in) && discharge_on |-> discharge_on [*8])
    else $error("Discharge released too early.");
  a_pg_after_ss: assert property
    ($fell(power_ok_oe) |-> $past(softstart_done_in, 2))
    else $error("Power good before soft start end.");
  a_pg_stays_low: assert property
    ($rose(power_ok_oe) |=> power_ok_oe [*8])
    else $error("Power good released too soon.");
  a_strap_frozen: assert property (!cal_window_in &&
    !$past(cal_window_in) && !$past(cal_window_in, 2) &&
    !$past(cal_window_in, 3) |-> $stable(skip_mode))
    else $error("Mode changed outside window.");
  a_light_in_skip: assert property (light_load |-> skip_mode)
    else $error("Light load without skip.");
  a_rdata_idle: assert property
    (!$past(reg_read) |-> reg_rdata == 32'h0000_0000)
    else $error("Read data outside its cycle.");
  a_uv_latch_off: assert property
    (uv_run > 13'h0CBC |-> !hs_drive && !ls_drive)
    else $error("Drives on after undervoltage delay.");
endmodule
bind bfs_top bfs_chk #(.DSCH_HOLD(DSCH_HOLD)) u_bfs_chk (.clock(clock),
  .rst_n(rst_n), .enable_in(enable_in), .bias_ok_in(bias_ok_in),
  .input_ok_in(input_ok_in), .over_temp_in(over_temp_in),
  .ext_ref_in_use(ext_ref_in_use), .uv_cmp_int(uv_cmp_int),
  .softstart_done_in(softstart_done_in), .cal_window_in(cal_window_in),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .hs_drive(hs_drive),
  .ls_drive(ls_drive), .discharge_on(discharge_on),
  .skip_mode(skip_mode), .light_load(light_load),
  .power_ok_oe(power_ok_oe));

/* bfs_host.sv */
// Host model: drives enable and reads the pulled-up power-good pin.
`timescale 1ns/1ns
module bfs_host (
  // Host side.
  input  wire logic clock,
  input  wire logic want_on,
  output logic      enable_in,
  // Pin side.
  input  wire logic power_ok_oe,
  output logic      pg_high
);
  // Restart is the host toggling enable, changed just after an edge.
  always @(posedge clock) enable_in <= want_on;
  // The pull-up lifts the pin whenever nobody pulls it low.
  assign pg_high = !power_ok_oe;
endmodule

/* bfs_top_test.sv */
// Self-checking testbench for the buck fault supervisor.
`timescale 1ns/1ns
`define CHK(a, e) begin #1; tests_run++; if ((a) !== (e)) begin \
  mismatches++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module bfs_top_test;
  import bfs_pkg::*;
  logic clock, rst_n, want_on, bias_ok_in, input_ok_in, over_temp_in;
  logic ext_ref_in_use, uv_cmp_int, uv_cmp_ext, ov_cmp_int, ov_cmp_ext;
  logic fb_below_100mv, softstart_done_in, cal_window_in, reg_write;
  logic reg_read, oob_cmp;
  logic [2:0] mode_strap_in;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, st;
  wire enable_in, pg_high, hs_drive, ls_drive, discharge_on, regulator_on;
  wire softstart_reset, skip_mode, light_load, power_ok_out, power_ok_oe;
  wire [1:0] freq_sel;
  int mismatches, tests_run;
  bfs_host u_bfs_host (.clock(clock), .want_on(want_on),
    .enable_in(enable_in), .power_ok_oe(power_ok_oe), .pg_high(pg_high));
  bfs_top #(.DSCH_HOLD(20)) u_bfs_top (.clock(clock), .rst_n(rst_n),
    .enable_in(enable_in), .bias_ok_in(bias_ok_in),
    .input_ok_in(input_ok_in), .over_temp_in(over_temp_in),
    .ext_ref_in_use(ext_ref_in_use), .uv_cmp_int(uv_cmp_int),
    .uv_cmp_ext(uv_cmp_ext), .ov_cmp_int(ov_cmp_int),
    .ov_cmp_ext(ov_cmp_ext), .oob_cmp(oob_cmp),
    .fb_below_100mv(fb_below_100mv), .softstart_done_in(softstart_done_in),
    .pwm_request_in(1'b0), .on_time_done_in(1'b0),
    .ls_current_ma(16'h0000), .limit_set_resistance(16'h1388),
    .mode_strap_in(mode_strap_in), .cal_window_in(cal_window_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .hs_drive(hs_drive),
    .ls_drive(ls_drive), .discharge_on(discharge_on),
    .regulator_on(regulator_on), .softstart_reset(softstart_reset),
    .skip_mode(skip_mode), .light_load(light_load), .freq_sel(freq_sel),
    .power_ok_out(power_ok_out), .power_ok_oe(power_ok_oe));
  // Free-running clock at 50 MHz.
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Register port cycles; read data is taken in its single cycle.
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 st = reg_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic t_reset;
    `CHK(power_ok_oe, 1'b1)
    `CHK({power_ok_out, light_load}, 2'b00)
    rd(REG_CTRL);
    `CHK(st[0], CTRL_SKIP_RST)
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C);
    `CHK(st, 32'h0000_0000)
    $display("test reset done");
  endtask
  // Every strap code inside the window, then a late change outside it.
  task automatic t_mode;
    for (int i = 0; i < 6; i++)
    begin
      cyc(1);
      mode_strap_in <= 3'(i);
      cal_window_in <= 1'b1;
      cyc(5);
      `CHK(skip_mode, 1'(i < 3))
      `CHK(freq_sel, 2'(12'h609 >> 2 * i))
    end
    cyc(1);
    cal_window_in <= 1'b0;
    cyc(2);
    mode_strap_in <= MODE_TIED_BIAS;
    cyc(6);
    `CHK(skip_mode, 1'b0)
    $display("test mode done");
  endtask
  task automatic t_start;
    cyc(1);
    want_on <= 1'b1;
    cyc(40);
    `CHK(pg_high, 1'b0)
    cyc(1);
    softstart_done_in <= 1'b1;
    cyc(10);
    `CHK(pg_high, 1'b1)
    cyc(1);
    oob_cmp <= 1'b1;
    cyc(3);
    rd(REG_STATUS);
    `CHK({st[6], st[2], ls_drive, pg_high}, 4'b1011)
    cyc(1);
    oob_cmp <= 1'b0;
    $display("test start done");
  endtask
  // Window judged on the external reference, then held out of bounds.
  task automatic t_pg;
    cyc(1);
    ext_ref_in_use <= 1'b1;
    ov_cmp_int <= 1'b1;
    cyc(300);
    `CHK(pg_high, 1'b1)
    cyc(1);
    ov_cmp_int <= 1'b0;
    ov_cmp_ext <= 1'b1;
    cyc(240);
    `CHK(pg_high, 1'b1)
    `CHK({hs_drive, ls_drive}, 2'b01)
    cyc(20);
    `CHK(pg_high, 1'b0)
    cyc(1);
    ov_cmp_ext <= 1'b0;
    ext_ref_in_use <= 1'b0;
    cyc(20);
    `CHK(pg_high, 1'b0)
    $display("test power good done");
  endtask
  // Two short dips with a gap, then a full one; enable toggle recovers.
  task automatic t_uv;
    cyc(1);
    uv_cmp_int <= 1'b1;
    cyc(3000);
    uv_cmp_int <= 1'b0;
    cyc(3);
    uv_cmp_int <= 1'b1;
    cyc(3000);
    uv_cmp_int <= 1'b0;
    rd(REG_STATUS);
    `CHK(st[2], 1'b0)
    cyc(1);
    uv_cmp_int <= 1'b1;
    cyc(3300);
    rd(REG_STATUS);
    `CHK(st[11:8], 4'h8)
    `CHK({hs_drive, ls_drive}, 2'b00)
    cyc(1);
    want_on <= 1'b0;
    uv_cmp_int <= 1'b0;
    cyc(10);
    want_on <= 1'b1;
    cyc(60);
    rd(REG_STATUS);
    `CHK(st[2], 1'b0)
    `CHK(pg_high, 1'b1)
    $display("test undervoltage done");
  endtask
  task automatic t_dsch;
    cyc(1);
    want_on <= 1'b0;
    cyc(10);
    `CHK(discharge_on, 1'b1)
    cyc(1);
    want_on <= 1'b1;
    cyc(12);
    `CHK(discharge_on, 1'b1)
    cyc(20);
    `CHK(discharge_on, 1'b0)
    cyc(1);
    over_temp_in <= 1'b1;
    cyc(5);
    `CHK({discharge_on, softstart_reset}, 2'b11)
    cyc(1);
    fb_below_100mv <= 1'b1;
    cyc(5);
    `CHK({discharge_on, regulator_on}, 2'b00)
    $display("test discharge done");
  endtask
  task automatic tally_and_finish;
    $display("Compared %0d, failed %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence after a 16-cycle reset.
  initial
  begin
    {want_on, over_temp_in, ext_ref_in_use, uv_cmp_int, uv_cmp_ext} = '0;
    {ov_cmp_int, ov_cmp_ext, fb_below_100mv, softstart_done_in} = '0;
    {cal_window_in, reg_write, reg_read, oob_cmp, mode_strap_in} = '0;
    {bias_ok_in, input_ok_in, rst_n} = 3'b110;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_reset;
    t_mode;
    t_start;
    t_pg;
    t_uv;
    t_dsch;
    tally_and_finish;
  end
  // Watchdog sized well above the roughly 10150 cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    tally_and_finish;
  end
endmodule
